// ---- tofd_pkg.sv ----
// Package for the temperature and open-load diagnostic flag bank.
// Assumes a 32-bit classic Wishbone slave port with a byte address.
package tofd_pkg;

  localparam int unsigned EXT_CHANNELS = 5;
  localparam int unsigned CELLS = 12;
  localparam int unsigned FLAG_W = 16;
  localparam int unsigned CODE_W = 10;
  localparam int unsigned ADR_W = 8;
  localparam int unsigned IDX_W = 6;

  // Register indices; the byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_EXT_TEMP = 6'h0E;
  localparam logic [IDX_W-1:0] IDX_CELL_OL = 6'h10;
  localparam logic [IDX_W-1:0] IDX_GENERAL_DIAGNOSIS_REGISTER = 6'h20;
  localparam logic [IDX_W-1:0] IDX_EXT_THR = 6'h21;

  // Values after reset
  localparam logic [FLAG_W-1:0] EXT_TEMP_RST = 16'h0000;
  localparam logic [FLAG_W-1:0] CELL_OL_RST = 16'h0000;
  localparam logic [CODE_W-1:0] EXT_THR_RST = 10'h000;

  // Implemented bits; reserved bits above read as zero
  localparam logic [FLAG_W-1:0] EXT_TEMP_MASK = 16'h7FFF;
  localparam logic [FLAG_W-1:0] CELL_OL_MASK = 16'h0FFF;

  // Per-channel field positions inside the external temperature register
  localparam int unsigned EXT_OPEN_POS = 0;
  localparam int unsigned EXT_SHORT_POS = 1;
  localparam int unsigned EXT_HEAT_POS = 2;
  localparam int unsigned EXT_STRIDE = 3;

  // Linked clear bits of the general diagnosis register
  localparam int unsigned GEN_CELL_OL_BIT = 0;
  localparam int unsigned GEN_EXT_TEMP_BIT = 1;

  // Bit of a given fault kind of an external channel
  function automatic int unsigned ext_bit(input int unsigned ch, input int unsigned kind);
    ext_bit = ch * EXT_STRIDE + kind;
  endfunction : ext_bit

endpackage : tofd_pkg

// ---- tofd_sticky_bank.sv ----
// Sticky flag bank: bits set by hardware events, cleared as a group.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/1ps
module tofd_sticky_bank #(
  parameter int unsigned WIDTH = 16,
  parameter logic [WIDTH-1:0] MASK = '1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] set_i,
  input wire logic clr_i,
  output logic [WIDTH-1:0] flags_o
);

  logic [WIDTH-1:0] flags_reg;
  logic [WIDTH-1:0] flags_next;

  // A set in the cycle of the clear survives, so no event is lost
  assign flags_next = ((flags_reg & ~{WIDTH{clr_i}}) | set_i) & MASK;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      flags_reg <= RST_VAL;
    else
      flags_reg <= flags_next;
  end

  assign flags_o = flags_reg;

endmodule : tofd_sticky_bank

// ---- tofd_heat_compare.sv ----
// Compares each external temperature conversion against the heat threshold.
// Assumes one conversion result per valid strobe, from same-clock logic.
`timescale 1ns/1ps
module tofd_heat_compare (
  input wire logic valid_i,
  input wire logic [2:0] chan_i,
  input wire logic [tofd_pkg::CODE_W-1:0] code_i,
  input wire logic [tofd_pkg::CODE_W-1:0] thr_i,
  output logic [tofd_pkg::EXT_CHANNELS-1:0] hot_o
);

  // A thermistor reads lower when hotter, so below the threshold is too hot
  wire below_thr = code_i < thr_i;

  always_comb
  begin
    hot_o = '0;
    for (int unsigned c = 0; c < tofd_pkg::EXT_CHANNELS; c++)
    begin
      // Channel numbers beyond the last channel are ignored
      if (valid_i && below_thr && (chan_i == 3'(c)))
        hot_o[c] = 1'b1;
    end
  end

endmodule : tofd_heat_compare

// ---- tofd_diag_flags.sv ----
// Temperature and open-load diagnostic flags behind a Wishbone slave.
// Assumes the diagnosis logic on the same clock delivers one-cycle events.
//
// Functional notes
// - Set channel heat alarm when its reading is below the heat threshold; bits 14,11,8,5,2.
// - Set channel short flag on detected short; bits 13,10,7,4,1.
// - Set channel open flag on detected open connection; bits 12,9,6,3,0.
// - Writing zero to the linked general diagnosis bit clears the flags.
// - Flags read zero after reset and one only after a detected fault.
// - Cell open-load register at index 10 hex, resets to 0000, kept in sleep.
// - One open-load flag per cell, cell n at bit n, cells 0 to 11.
// - Bits 15 to 12 of the cell open-load register are reserved, reading zero.
// - External temperature register resets to 0000, kept in sleep, bit 15 reserved.
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ps
module tofd_diag_flags (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [tofd_pkg::ADR_W-1:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  input wire logic ext_code_valid_i,
  input wire logic [2:0] ext_code_chan_i,
  input wire logic [tofd_pkg::CODE_W-1:0] ext_code_i,
  input wire logic [tofd_pkg::EXT_CHANNELS-1:0] ext_short_evt_i,
  input wire logic [tofd_pkg::EXT_CHANNELS-1:0] ext_open_evt_i,
  input wire logic [tofd_pkg::CELLS-1:0] cell_open_evt_i,
  output logic [tofd_pkg::FLAG_W-1:0] ext_temp_fault_flags_o,
  output logic [tofd_pkg::FLAG_W-1:0] cell_openload_flags_o,
  output logic fault_present_o
);

  logic ack_reg;
  logic ack_next;
  logic err_reg;
  logic err_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [tofd_pkg::CODE_W-1:0] ext_heat_threshold_reg;
  logic [tofd_pkg::CODE_W-1:0] ext_heat_threshold_next;
  logic fault_reg;
  logic fault_next;

  logic [tofd_pkg::FLAG_W-1:0] ext_temp_fault_flags;
  logic [tofd_pkg::FLAG_W-1:0] cell_openload_flags;
  logic [tofd_pkg::FLAG_W-1:0] ext_set;
  logic [tofd_pkg::FLAG_W-1:0] cell_set;
  logic [tofd_pkg::EXT_CHANNELS-1:0] ext_hot;
  logic [tofd_pkg::FLAG_W-1:0] general_diagnosis_register;

  // Bus decode
  wire [tofd_pkg::IDX_W-1:0] idx = adr_i[tofd_pkg::ADR_W-1:2];
  wire req = cyc_i & stb_i;
  wire hit_ext_temp = idx == tofd_pkg::IDX_EXT_TEMP;
  wire hit_cell_ol = idx == tofd_pkg::IDX_CELL_OL;
  wire hit_general_diagnosis_register = idx == tofd_pkg::IDX_GENERAL_DIAGNOSIS_REGISTER;
  wire hit_ext_thr = idx == tofd_pkg::IDX_EXT_THR;
  wire mapped = hit_ext_temp | hit_cell_ol | hit_general_diagnosis_register | hit_ext_thr;
  wire busy = ack_reg | err_reg;

  // Writes take effect at the edge where the master samples ack high
  wire wr_commit = req & we_i & ack_reg;
  wire wr_general_diagnosis_register = wr_commit & hit_general_diagnosis_register & sel_i[0];
  wire wr_thr_lo = wr_commit & hit_ext_thr & sel_i[0];
  wire wr_thr_hi = wr_commit & hit_ext_thr & sel_i[1];

  // Zero in a linked bit clears; a one leaves the flags alone
  wire clr_cell_ol = wr_general_diagnosis_register & ~dat_i[tofd_pkg::GEN_CELL_OL_BIT];
  wire clr_ext_temp = wr_general_diagnosis_register & ~dat_i[tofd_pkg::GEN_EXT_TEMP_BIT];

  assign ack_next = req & mapped & ~busy;
  assign err_next = req & ~mapped & ~busy;

  // Threshold is the one register software steers the block with
  always_comb
  begin
    ext_heat_threshold_next = ext_heat_threshold_reg;
    if (wr_thr_lo)
      ext_heat_threshold_next[7:0] = dat_i[7:0];
    if (wr_thr_hi)
      ext_heat_threshold_next[tofd_pkg::CODE_W-1:8] = dat_i[tofd_pkg::CODE_W-1:8];
  end

  tofd_heat_compare u_heat_compare (
    .valid_i(ext_code_valid_i),
    .chan_i(ext_code_chan_i),
    .code_i(ext_code_i),
    .thr_i(ext_heat_threshold_reg),
    .hot_o(ext_hot)
  );

  // Place each channel's three fault kinds into its field triplet
  always_comb
  begin
    ext_set = '0;
    for (int unsigned c = 0; c < tofd_pkg::EXT_CHANNELS; c++)
    begin
      ext_set[tofd_pkg::ext_bit(c, tofd_pkg::EXT_HEAT_POS)] = ext_hot[c];
      ext_set[tofd_pkg::ext_bit(c, tofd_pkg::EXT_SHORT_POS)] = ext_short_evt_i[c];
      ext_set[tofd_pkg::ext_bit(c, tofd_pkg::EXT_OPEN_POS)] = ext_open_evt_i[c];
    end
  end

  // Cell n lands on bit n; reserved bits never get set
  assign cell_set = {{(tofd_pkg::FLAG_W - tofd_pkg::CELLS){1'b0}}, cell_open_evt_i};

  // Only hardware events and the linked clear reach the banks
  tofd_sticky_bank #(
    .WIDTH(tofd_pkg::FLAG_W),
    .MASK(tofd_pkg::EXT_TEMP_MASK),
    .RST_VAL(tofd_pkg::EXT_TEMP_RST)
  ) u_ext_temp_bank (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(ext_set),
    .clr_i(clr_ext_temp),
    .flags_o(ext_temp_fault_flags)
  );

  tofd_sticky_bank #(
    .WIDTH(tofd_pkg::FLAG_W),
    .MASK(tofd_pkg::CELL_OL_MASK),
    .RST_VAL(tofd_pkg::CELL_OL_RST)
  ) u_cell_ol_bank (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(cell_set),
    .clr_i(clr_cell_ol),
    .flags_o(cell_openload_flags)
  );

  // Linked bits read one while any flag of their register is set
  always_comb
  begin
    general_diagnosis_register = '0;
    general_diagnosis_register[tofd_pkg::GEN_CELL_OL_BIT] = |cell_openload_flags;
    general_diagnosis_register[tofd_pkg::GEN_EXT_TEMP_BIT] = |ext_temp_fault_flags;
  end

  // Read mux; reserved bits and upper half read zero
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    if (req & ~we_i & ~busy)
    begin
      if (hit_ext_temp)
        rdata_next[tofd_pkg::FLAG_W-1:0] = ext_temp_fault_flags & tofd_pkg::EXT_TEMP_MASK;
      if (hit_cell_ol)
        rdata_next[tofd_pkg::FLAG_W-1:0] = cell_openload_flags & tofd_pkg::CELL_OL_MASK;
      if (hit_general_diagnosis_register)
        rdata_next[tofd_pkg::FLAG_W-1:0] = general_diagnosis_register;
      if (hit_ext_thr)
        rdata_next[tofd_pkg::CODE_W-1:0] = ext_heat_threshold_reg;
    end
  end

  assign fault_next = (|ext_temp_fault_flags) | (|cell_openload_flags);

  // No sleep input exists here: contents persist until reset or linked clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      ext_heat_threshold_reg <= tofd_pkg::EXT_THR_RST;
      fault_reg <= 1'b0;
    end
    else
    begin
      ack_reg <= ack_next;
      err_reg <= err_next;
      rdata_reg <= rdata_next;
      ext_heat_threshold_reg <= ext_heat_threshold_next;
      fault_reg <= fault_next;
    end
  end

  assign ack_o = ack_reg;
  assign err_o = err_reg;
  assign dat_o = rdata_reg;
  assign ext_temp_fault_flags_o = ext_temp_fault_flags;
  assign cell_openload_flags_o = cell_openload_flags;
  assign fault_present_o = fault_reg;

endmodule : tofd_diag_flags

// ---- tofd_diag_flags_monitor.sv ----
// Checker for the diagnostic flag bank, bound to its top module.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module tofd_diag_flags_mon (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ext_code_valid_i,
  input wire logic [4:0] ext_short_evt_i,
  input wire logic [4:0] ext_open_evt_i,
  input wire logic [11:0] cell_open_evt_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic err_o,
  input wire logic [15:0] ext_temp_fault_flags_o,
  input wire logic [15:0] cell_openload_flags_o,
  input wire logic fault_present_o
);
  wire [31:0] fl = {ext_temp_fault_flags_o, cell_openload_flags_o};
  wire wr_gen = cyc_i && stb_i && we_i && (adr_i == 8'h80);
  wire rd_cell = cyc_i && stb_i && !we_i && !ack_o && (adr_i == 8'h40);
  wire quiet = !ext_code_valid_i && ext_short_evt_i == 5'h00 && ext_open_evt_i == 5'h00;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack; cyc_i && stb_i && !ack_o && !err_o |=> ack_o != err_o; endproperty
  a_ack: assert property (p_ack) else $error("bus answer missing or doubled");
  property p_short; ext_short_evt_i[4] |=> ext_temp_fault_flags_o[13]; endproperty
  a_short: assert property (p_short) else $error("short flag not set");
  property p_open; ext_open_evt_i[0] |=> ext_temp_fault_flags_o[0]; endproperty
  a_open: assert property (p_open) else $error("open flag not set");
  property p_cell; cell_open_evt_i[11] |=> cell_openload_flags_o[11]; endproperty
  a_cell: assert property (p_cell) else $error("cell flag not set");
  property p_res; !fl[31] && fl[15:12] == 4'h0; endproperty
  a_res: assert property (p_res) else $error("reserved bit set");
  property p_rst; $fell(rst_i) |-> fl == 32'h0000_0000 && !fault_present_o; endproperty
  a_rst: assert property (p_rst) else $error("flags not clear after reset");
  property p_keep; !wr_gen |=> (fl & $past(fl)) == $past(fl); endproperty
  a_keep: assert property (p_keep) else $error("flag lost without clear");
  property p_clr; wr_gen && ack_o && sel_i[0] && !dat_i[1] && quiet |=> fl[31:16] == 16'h0000;
  endproperty
  a_clr: assert property (p_clr) else $error("linked clear ignored");
  property p_fp; 1'b1 |=> fault_present_o == $past(fl != 32'h0000_0000); endproperty
  a_fp: assert property (p_fp) else $error("summary flag wrong");
  property p_rd; rd_cell |=> ack_o && dat_o == {16'h0000, $past(cell_openload_flags_o)}; endproperty
  a_rd: assert property (p_rd) else $error("cell register read wrong");
  c_ack: cover property (ack_o);
  c_err: cover property (err_o);
  c_fp: cover property (fault_present_o);
endmodule : tofd_diag_flags_mon

// ---- tb_top.sv ----
// Testbench for the diagnostic flag bank: bus tasks and hand-written scenarios.
// Assumes the register map at bytes 0x38, 0x40, 0x80 and 0x84, one clock, no other model.
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [3:0] sel_i = 4'h3;
  logic we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0, ext_code_valid_i = 1'b0;
  logic [2:0] ext_code_chan_i = 3'h0;
  logic [9:0] ext_code_i = 10'h000;
  logic [4:0] ext_short_evt_i = 5'h00, ext_open_evt_i = 5'h00;
  logic [11:0] cell_open_evt_i = 12'h000;
  logic [31:0] dat_o, q;
  logic ack_o, err_o, fault_present_o, last_err;
  logic [15:0] ext_temp_fault_flags_o, cell_openload_flags_o;
  int bad_count = 0;
  int total_checks = 0;
  always #2.5 clk_i = ~clk_i;
  tofd_diag_flags uut (.clk_i, .rst_i, .adr_i, .dat_i, .sel_i, .we_i, .cyc_i, .stb_i, .dat_o,
    .ack_o, .err_o, .ext_code_valid_i, .ext_code_chan_i, .ext_code_i, .ext_short_evt_i,
    .ext_open_evt_i, .cell_open_evt_i, .ext_temp_fault_flags_o, .cell_openload_flags_o,
    .fault_present_o);
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Request stands up to the rising edge that sees the answer; data is taken at that edge
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, sel_i, adr_i, dat_i} <= {2'b11, w, 4'h3, a, d};
    @(posedge clk_i);
    while (ack_o !== 1'b1 && err_o !== 1'b1)
    begin
      n++;
      if (n > 20)
      begin
        bad_count++;
        end_of_test();
      end
      @(posedge clk_i);
    end
    q = dat_o;
    last_err = err_o;
    {cyc_i, stb_i, we_i} <= 3'b000;
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(a, 1'b0, 32'h0000_0000);
    chk(q, e);
  endtask : rd
  task automatic t_set;
    wb(8'h84, 1'b1, 32'h0000_0100);
    @(posedge clk_i);
    {ext_short_evt_i, ext_open_evt_i, cell_open_evt_i} <= {5'h10, 5'h01, 12'h801};
    {ext_code_valid_i, ext_code_chan_i, ext_code_i} <= {1'b1, 3'h3, 10'h0FF};
    @(posedge clk_i);
    {ext_short_evt_i, ext_open_evt_i, cell_open_evt_i} <= 22'h00_0000;
    {ext_code_chan_i, ext_code_i} <= {3'h1, 10'h100};
    @(posedge clk_i);
    // Channel numbers past the last one must not raise any alarm
    {ext_code_chan_i, ext_code_i} <= {3'h7, 10'h000};
    @(posedge clk_i);
    ext_code_valid_i <= 1'b0;
    rd(8'h38, 32'h0000_2801);
    rd(8'h40, 32'h0000_0801);
    rd(8'h84, 32'h0000_0100);
    chk({16'h0000, ext_temp_fault_flags_o}, 32'h0000_2801);
    chk({16'h0000, cell_openload_flags_o}, 32'h0000_0801);
    chk({31'h0, fault_present_o}, 32'h0000_0001);
  endtask : t_set
  task automatic t_direct;
    wb(8'h38, 1'b1, 32'h0000_0000);
    wb(8'h40, 1'b1, 32'h0000_FFFF);
    rd(8'h38, 32'h0000_2801);
    rd(8'h40, 32'h0000_0801);
    wb(8'hFC, 1'b0, 32'h0000_0000);
    chk({31'h0, last_err}, 32'h0000_0001);
  endtask : t_direct
  task automatic t_clear;
    wb(8'h80, 1'b1, 32'h0000_0001);
    rd(8'h38, 32'h0000_0000);
    rd(8'h80, 32'h0000_0001);
    wb(8'h80, 1'b1, 32'h0000_0000);
    rd(8'h40, 32'h0000_0000);
    chk({31'h0, fault_present_o}, 32'h0000_0000);
  endtask : t_clear
  // Reset in mid-run must wipe flags that hardware had set
  task automatic t_reset;
    @(posedge clk_i);
    cell_open_evt_i <= 12'h004;
    ext_open_evt_i <= 5'h04;
    @(posedge clk_i);
    cell_open_evt_i <= 12'h000;
    ext_open_evt_i <= 5'h00;
    @(posedge clk_i);
    chk({16'h0000, cell_openload_flags_o}, 32'h0000_0004);
    chk({16'h0000, ext_temp_fault_flags_o}, 32'h0000_0040);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h40, 32'h0000_0000);
    rd(8'h38, 32'h0000_0000);
    chk({16'h0000, ext_temp_fault_flags_o}, 32'h0000_0000);
    chk({31'h0, fault_present_o}, 32'h0000_0000);
  endtask : t_reset
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h38, 32'h0000_0000);
    rd(8'h40, 32'h0000_0000);
    t_set();
    t_direct();
    t_clear();
    t_reset();
    end_of_test();
  end
endmodule : tb_top
bind tofd_diag_flags tofd_diag_flags_mon mon (.clk_i, .rst_i, .adr_i, .dat_i, .sel_i, .we_i,
  .cyc_i, .stb_i, .ext_code_valid_i, .ext_short_evt_i, .ext_open_evt_i, .cell_open_evt_i,
  .dat_o, .ack_o, .err_o, .ext_temp_fault_flags_o, .cell_openload_flags_o, .fault_present_o);
